// file: rtl/hle_pkg.sv
`default_nettype none
package hle_pkg;
  // ----------------------------------------
  // clocking and serial timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ  = 250_000_000;
  localparam int unsigned BAUD    = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam logic [3:0]  TX_BITS_PAR   = 4'hb;
  localparam logic [3:0]  TX_BITS_NOPAR = 4'ha;
  localparam logic [10:0] TX_IDLE       = 11'h7ff;
  // ----------------------------------------
  // host port register offsets
  // ----------------------------------------
  localparam logic [2:0] REG_CSUM_HI = 3'h6;
  localparam logic [2:0] REG_COMM    = 3'h7;
  // ----------------------------------------
  // characters and mode values
  // ----------------------------------------
  localparam logic [7:0] CH_BELL   = 8'h07;
  localparam logic [7:0] CH_ACK    = 8'h06;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_CTRL_T = 8'h14;
  localparam logic [7:0] CH_SPACE  = 8'h20;
  localparam logic [7:0] CH_DEL    = 8'h7f;
  localparam logic [1:0] CSUM_MODE = 2'h1;
  localparam logic [1:0] HS_NONE   = 2'h0;
  localparam logic [1:0] HS_LF     = 2'h1;
  // ----------------------------------------
  // input queue
  // ----------------------------------------
  localparam int unsigned FIFO_W     = 10;
  localparam int unsigned FIFO_DEPTH = 16;
  // ----------------------------------------
  // state encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_RSUM = 3'b010,
    SQ_CSUM = 3'b100
  } hle_seq_t;
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } hle_rx_st_t;
endpackage
`default_nettype wire

// file: rtl/hle_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module hle_fifo #(
  parameter int unsigned W     = 10,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } hle_fifo_state_t;
  hle_fifo_state_t q;
  hle_fifo_state_t n;
  logic            push;
  logic            load;

  assign in_ready  = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.ov;
  assign out_data  = q.od;

  always_comb
  begin
    n    = q;
    push = in_valid & in_ready;
    load = (q.cnt != '0) & (!q.ov | out_ready);
    if (push)
    begin
      n.mem[q.wp] = in_data;
      n.wp        = q.wp + 1'b1;
    end
    // head word sits in a register so the reader sees flop data
    if (!q.ov | out_ready)
    begin
      n.ov = load;
      if (load)
      begin
        n.od = q.mem[q.rp];
        n.rp = q.rp + 1'b1;
      end
    end
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= n;
  end

  fill_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.cnt <= (AW+1)'(DEPTH)) else $error("queue count past depth");
endmodule
`default_nettype wire

// file: rtl/hle_rx.sv
`timescale 1ns/10ps
`default_nettype none
module hle_rx #(
  parameter int unsigned BIT_CYC = hle_pkg::BIT_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // serial line and parity option
  input  wire logic       rxd,
  input  wire logic       par_en,
  // received character, one-cycle pulse
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_err
);
  typedef struct packed {
    logic [1:0]         sync;
    hle_pkg::hle_rx_st_t st;
    logic [15:0]        cnt;
    logic [3:0]         bit_n;
    logic [7:0]         sh;
    logic               perr;
    logic               valid;
    logic [7:0]         data;
    logic               err;
  } hle_rx_state_t;
  hle_rx_state_t q;
  hle_rx_state_t n;
  logic          line;

  assign line     = q.sync[1];
  assign rx_valid = q.valid;
  assign rx_data  = q.data;
  assign rx_err   = q.err;

  always_comb
  begin
    n       = q;
    n.sync  = {q.sync[0], rxd};
    n.valid = 1'b0;
    if (q.cnt != '0)
      n.cnt = q.cnt - 16'h0001;
    unique case (q.st)
      hle_pkg::RX_IDLE:
        if (!line)
        begin
          n.st  = hle_pkg::RX_START;
          n.cnt = 16'(BIT_CYC / 2);
        end
      hle_pkg::RX_START:
        if (q.cnt == '0)
        begin
          n.st    = line ? hle_pkg::RX_IDLE : hle_pkg::RX_DATA;
          n.cnt   = 16'(BIT_CYC - 1);
          n.bit_n = '0;
        end
      hle_pkg::RX_DATA:
        if (q.cnt == '0)
        begin
          n.sh    = {line, q.sh[7:1]};
          n.bit_n = q.bit_n + 4'h1;
          n.cnt   = 16'(BIT_CYC - 1);
          if (q.bit_n == 4'h7)
            n.st = par_en ? hle_pkg::RX_PAR : hle_pkg::RX_STOP;
          n.perr = 1'b0;
        end
      hle_pkg::RX_PAR:
        if (q.cnt == '0)
        begin
          n.perr = ~^{q.sh, line};
          n.cnt  = 16'(BIT_CYC - 1);
          n.st   = hle_pkg::RX_STOP;
        end
      hle_pkg::RX_STOP:
        if (q.cnt == '0)
        begin
          // a stray parity bit lands here as the stop bit, an error when low
          n.valid = 1'b1;
          n.data  = q.sh;
          n.err   = q.perr | !line;
          n.st    = hle_pkg::RX_IDLE;
        end
      default:
        n.st = hle_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q      <= '0;
      q.sync <= 2'h3;
      q.st   <= hle_pkg::RX_IDLE;
    end
    else
      q <= n;
  end
endmodule
`default_nettype wire

// file: rtl/hle_top.sv
// Summary of operation
// - jumper absent: check odd parity on receive, append odd parity on transmit.
// - character error flags the line; at CR the line is rejected.
// - check mode 0 or 1: bell sent at once on a character error.
// - jumper fitted: no parity either way; a stray parity bit of 0 gives framing error.
// - framing always checked and handled like a parity error.
// - half duplex after reset; CTRL-T toggles duplex; full duplex echoes.
// - echo is taken from the stored queue copy of the character.
// - checksums only in check mode 1, on serial and parallel ports.
// - checksum is the plain sum of byte codes.
// - device never compares checksums; host never sends one.
// - command checksum skips all control characters and the CR.
// - acknowledge per handshake mode, then command checksum right after.
// - data response and its checksum go before acknowledge and command checksum.
// - syntax error gives bell, no checksum, line discarded.
// - response line checksum counts every character, sent after its CR.
// - program output carries line checksums only, no acknowledge.
// - serial port sends only the low checksum byte.
// - parallel port shows low byte at offset 7, high byte at 6.
`timescale 1ns/10ps
`default_nettype none
module hle_top #(
  parameter int unsigned BIT_CYC = hle_pkg::BIT_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // jumper and mode settings
  input  wire logic       parity_disable_jumper,
  input  wire logic [1:0] comm_check_mode_setting,
  input  wire logic [1:0] handshake_mode_setting,
  input  wire logic       use_parallel_port,
  // serial port
  input  wire logic       ser_rxd,
  output logic            ser_txd,
  // parallel host port
  input  wire logic [2:0] host_addr,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_wdata,
  output logic [7:0]      host_rdata,
  output logic            host_busy,
  output logic            host_out_full,
  // received characters to the parser
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  output logic [7:0]      cmd_data,
  output logic            cmd_reject,
  // outgoing response characters
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [7:0] out_data,
  // end of a host command
  input  wire logic       done_valid,
  output logic            done_ready,
  input  wire logic       done_syntax_err
);
  typedef struct packed {
    logic [1:0]       jmp;
    logic             duplex;
    logic             line_err;
    logic             bell_pend;
    logic             echo_pend;
    logic [7:0]       echo_byte;
    logic [15:0]      cmd_sum;
    logic [15:0]      cmd_hold;
    logic [15:0]      resp_sum;
    hle_pkg::hle_seq_t sq;
    logic [10:0]      tx_sh;
    logic [3:0]       tx_n;
    logic [15:0]      tx_cnt;
    logic [7:0]       par_out;
    logic [7:0]       par_hi;
    logic             par_full;
    logic [7:0]       rdata;
  } hle_top_state_t;

  hle_top_state_t q;
  hle_top_state_t n;
  logic [1:0]     rst_sync;
  logic           rst_n_s;
  logic           par_en;
  logic           csum_on;
  logic           rx_valid;
  logic [7:0]     rx_data;
  logic           rx_err;
  logic           rx_go;
  logic           in_go;
  logic [7:0]     in_ch;
  logic           f_push;
  logic           f_in_ready;
  logic [9:0]     f_in_data;
  logic           f_valid;
  logic           f_pop;
  logic [9:0]     f_data;
  logic           e_go;
  logic [7:0]     e_byte;
  logic [7:0]     e_hi;
  logic           free;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n_s = rst_sync[1];

  // ----------------------------------------
  // serial receiver and input queue
  // ----------------------------------------
  hle_rx #(
    .BIT_CYC (BIT_CYC)
  ) u_rx (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n_s),
    .rxd      (ser_rxd),
    .par_en   (par_en),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_err   (rx_err)
  );

  hle_fifo #(
    .W     (hle_pkg::FIFO_W),
    .DEPTH (hle_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n_s),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  assign par_en        = !q.jmp[1];
  assign csum_on       = comm_check_mode_setting == hle_pkg::CSUM_MODE;
  assign rx_go         = rx_valid & !use_parallel_port;
  assign in_go         = rx_go | (host_wr & use_parallel_port & host_addr == hle_pkg::REG_COMM);
  assign in_ch         = rx_go ? rx_data : host_wdata;
  assign cmd_valid     = f_valid & !q.echo_pend;
  assign f_pop         = cmd_valid & cmd_ready;
  assign cmd_data      = f_data[7:0];
  assign cmd_reject    = f_data[8];
  assign free          = use_parallel_port ? !q.par_full : (q.tx_n == '0);
  assign host_busy     = !f_in_ready;
  assign host_out_full = q.par_full;
  assign host_rdata    = q.rdata;
  assign ser_txd       = q.tx_sh[0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    n          = q;
    n.jmp      = {q.jmp[0], parity_disable_jumper};
    f_push     = 1'b0;
    f_in_data  = {rx_go, q.line_err, in_ch};
    e_go       = 1'b0;
    e_byte     = '0;
    e_hi       = '0;
    out_ready  = 1'b0;
    done_ready = 1'b0;

    // host register reads; a read of the comm byte frees it
    if (host_rd)
    begin
      n.rdata = '0;
      if (host_addr == hle_pkg::REG_COMM)
      begin
        n.rdata    = q.par_out;
        n.par_full = 1'b0;
      end
      else if (host_addr == hle_pkg::REG_CSUM_HI)
        n.rdata = q.par_hi;
    end

    // transmit shifter
    if (q.tx_n != '0)
    begin
      if (q.tx_cnt == '0)
      begin
        n.tx_sh  = {1'b1, q.tx_sh[10:1]};
        n.tx_n   = q.tx_n - 4'h1;
        n.tx_cnt = 16'(BIT_CYC - 1);
      end
      else
        n.tx_cnt = q.tx_cnt - 16'h0001;
    end

    // output sequencer: bell, echo, response, then command end
    if (free)
    begin
      unique case (q.sq)
        hle_pkg::SQ_RSUM:
        begin
          e_go       = 1'b1;
          e_byte     = q.resp_sum[7:0];
          e_hi       = q.resp_sum[15:8];
          n.resp_sum = '0;
          n.sq       = hle_pkg::SQ_IDLE;
        end
        hle_pkg::SQ_CSUM:
        begin
          e_go   = 1'b1;
          e_byte = q.cmd_hold[7:0];
          e_hi   = q.cmd_hold[15:8];
          n.sq   = hle_pkg::SQ_IDLE;
        end
        hle_pkg::SQ_IDLE:
          if (q.bell_pend)
          begin
            e_go        = 1'b1;
            e_byte      = hle_pkg::CH_BELL;
            n.bell_pend = 1'b0;
          end
          else if (q.echo_pend)
          begin
            // echo only has meaning on the serial line
            e_go        = !use_parallel_port;
            e_byte      = q.echo_byte;
            n.echo_pend = 1'b0;
          end
          else if (out_valid)
          begin
            out_ready  = 1'b1;
            e_go       = 1'b1;
            e_byte     = out_data;
            n.resp_sum = q.resp_sum + {8'h00, out_data};
            if (out_data == hle_pkg::CH_CR)
            begin
              if (csum_on)
                n.sq = hle_pkg::SQ_RSUM;
              else
                n.resp_sum = '0;
            end
          end
          else if (done_valid)
          begin
            done_ready = 1'b1;
            e_go       = 1'b1;
            if (done_syntax_err)
              e_byte = hle_pkg::CH_BELL;
            else
            begin
              unique case (handshake_mode_setting)
                hle_pkg::HS_NONE: e_go   = 1'b0;
                hle_pkg::HS_LF:   e_byte = hle_pkg::CH_LF;
                default:          e_byte = hle_pkg::CH_ACK;
              endcase
              if (csum_on)
                n.sq = hle_pkg::SQ_CSUM;
            end
          end
        default:
          n.sq = hle_pkg::SQ_IDLE;
      endcase
    end

    if (e_go)
    begin
      if (use_parallel_port)
      begin
        n.par_out  = e_byte;
        n.par_hi   = e_hi;
        n.par_full = 1'b1;
      end
      else
      begin
        // only the low byte of a sum leaves by the serial line
        n.tx_cnt = 16'(BIT_CYC - 1);
        if (par_en)
        begin
          n.tx_sh = {1'b1, ~^e_byte, e_byte, 1'b0};
          n.tx_n  = hle_pkg::TX_BITS_PAR;
        end
        else
        begin
          n.tx_sh = {2'b11, e_byte, 1'b0};
          n.tx_n  = hle_pkg::TX_BITS_NOPAR;
        end
      end
    end

    // stored copy feeds the echo
    if (f_pop && f_data[9] && q.duplex)
    begin
      n.echo_pend = 1'b1;
      n.echo_byte = f_data[7:0];
    end

    // receive side; flag sets come last so they win over clears
    if (in_go)
    begin
      if ((rx_go && rx_err) || !f_in_ready)
      begin
        n.line_err = 1'b1;
        if (!comm_check_mode_setting[1])
          n.bell_pend = 1'b1;
      end
      else if (rx_go && in_ch == hle_pkg::CH_CTRL_T)
        n.duplex = !q.duplex;
      else
      begin
        f_push = 1'b1;
        if (in_ch == hle_pkg::CH_CR)
        begin
          n.cmd_hold = q.cmd_sum;
          n.cmd_sum  = '0;
          n.line_err = 1'b0;
          if (q.line_err)
            n.bell_pend = 1'b1;
        end
        else if (in_ch >= hle_pkg::CH_SPACE && in_ch != hle_pkg::CH_DEL)
          n.cmd_sum = q.cmd_sum + {8'h00, in_ch};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      q       <= '0;
      q.sq    <= hle_pkg::SQ_IDLE;
      q.tx_sh <= hle_pkg::TX_IDLE;
    end
    else
      q <= n;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n_s);

  err_bell_a: assert property (
    in_go && rx_go && rx_err && !comm_check_mode_setting[1] |=> q.bell_pend && q.line_err)
    else $error("no bell after character error");
  reject_bell_a: assert property (
    f_push && in_ch == hle_pkg::CH_CR && q.line_err |=> q.bell_pend && !q.line_err)
    else $error("flagged line not rejected");
  duplex_flip_a: assert property (
    in_go && rx_go && !rx_err && f_in_ready && in_ch == hle_pkg::CH_CTRL_T
    |=> q.duplex != $past(q.duplex)) else $error("duplex did not toggle");
  ctl_skip_a: assert property (
    f_push && in_ch < hle_pkg::CH_SPACE |=> $stable(q.cmd_sum) || q.cmd_sum == '0)
    else $error("control char summed");
  sum_add_a: assert property (
    f_push && in_ch >= hle_pkg::CH_SPACE && in_ch != hle_pkg::CH_DEL
    |=> q.cmd_sum == $past(q.cmd_sum) + {8'h00, $past(in_ch)}) else $error("bad command sum");
  resp_csum_a: assert property (
    out_ready && out_valid && out_data == hle_pkg::CH_CR && csum_on
    |=> q.sq == hle_pkg::SQ_RSUM ##0 q.resp_sum == $past(q.resp_sum) + 16'h000d)
    else $error("no line checksum after CR");
  mode0_csum_a: assert property (
    (out_ready && out_valid || done_ready && done_valid) && !csum_on
    |=> q.sq == hle_pkg::SQ_IDLE) else $error("checksum queued while off");
  syntax_bell_a: assert property (
    done_ready && done_valid && done_syntax_err
    |-> e_go && e_byte == hle_pkg::CH_BELL ##1 q.sq == hle_pkg::SQ_IDLE)
    else $error("syntax error not answered by bell alone");
  echo_copy_a: assert property (
    f_pop && f_data[9] && q.duplex |=> q.echo_pend && q.echo_byte == $past(f_data[7:0]))
    else $error("echo not from stored copy");
  tx_parity_a: assert property (
    e_go && !use_parallel_port && par_en
    |=> q.tx_n == hle_pkg::TX_BITS_PAR && ^q.tx_sh[9:1]) else $error("odd parity missing");
  tx_nopar_a: assert property (
    e_go && !use_parallel_port && !par_en |=> q.tx_n == hle_pkg::TX_BITS_NOPAR)
    else $error("parity sent while disabled");
  csum_hi_a: assert property (
    e_go && use_parallel_port && q.sq == hle_pkg::SQ_CSUM
    |=> q.par_hi == $past(q.cmd_hold[15:8]) && q.par_full) else $error("high byte missing");

  bell_sent_c: cover property (e_go && e_byte == hle_pkg::CH_BELL);
  cmd_csum_c:  cover property (e_go && q.sq == hle_pkg::SQ_CSUM);
  echo_c:      cover property (e_go && q.echo_pend);
  reject_c:    cover property (f_pop && cmd_reject);
endmodule
`default_nettype wire

// file: bench/hle_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hle_host_model #(
  parameter int BC = 4
) (
  // clock and parity option
  input  wire logic sys_clk,
  input  wire logic par_en,
  // serial lines, host view
  output logic      txd,
  input  wire logic rxd
);
  // ----------------------------------------
  // receive side: every byte the device sends
  // ----------------------------------------
  logic [7:0] rxq[$];
  logic [7:0] b;
  int         bad_cnt = 0;
  initial txd = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  always
  begin
    @(negedge rxd);
    tick(BC / 2);
    for (int i = 0; i < 8; i++)
    begin
      tick(BC);
      b[i] = rxd;
    end
    if (par_en)
    begin
      tick(BC);
      if (rxd !== ~^b) bad_cnt++;
    end
    tick(BC);
    if (rxd !== 1'b1) bad_cnt++;
    rxq.push_back(b);
  end
  // ----------------------------------------
  // send side; flip spoils the parity bit
  // ----------------------------------------
  task automatic send(input logic [7:0] c, input bit pb, input bit fl);
    logic [10:0] f;
    int          n;
    n = pb ? 11 : 10;
    f = pb ? {1'b1, ~^c ^ fl, c, 1'b0} : {2'b11, c, 1'b0};
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      txd <= f[i];
      tick(BC - 1);
    end
  endtask
endmodule
`default_nettype wire

// file: bench/host_link_error_check_test.sv
`timescale 1ns/10ps
`default_nettype none
module host_link_error_check_test;
  logic       sys_clk, rstn = 1'b0, ser_rxd, ser_txd, cmd_valid, cmd_reject;
  logic       jmp = 1'b0, use_parallel_port = 1'b0, cmd_ready = 1'b1;
  logic       host_wr = 1'b0, host_rd = 1'b0, host_busy, host_out_full;
  logic       out_valid = 1'b0, out_ready, done_valid = 1'b0, done_ready;
  logic       done_syntax_err = 1'b0, rej;
  logic [1:0] ccm = 2'h1, hsm = 2'h3;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_wdata = 8'h00, host_rdata, cmd_data, out_data = 8'h00, d6, d7;
  logic [7:0] pops[$], e[$];
  int         error_cnt = 0, n_tests = 0;
  string      qs = "Q10..12\015";
  hle_top #(.BIT_CYC(4)) i_dut (.sys_clk, .rstn, .parity_disable_jumper(jmp),
    .comm_check_mode_setting(ccm), .handshake_mode_setting(hsm), .use_parallel_port,
    .ser_rxd, .ser_txd, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
    .host_busy, .host_out_full, .cmd_valid, .cmd_ready, .cmd_data, .cmd_reject,
    .out_valid, .out_ready, .out_data, .done_valid, .done_ready, .done_syntax_err);
  hle_host_model #(.BC(4)) i_host (.sys_clk, .par_en(!jmp), .txd(ser_rxd), .rxd(ser_txd));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // parser stand-in: takes every head character
  always @(posedge sys_clk)
    if (cmd_valid === 1'b1)
    begin
      pops.push_back(cmd_data);
      if (cmd_reject === 1'b1)
        rej = 1'b1;
    end
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // w 0: line end popped, 1: n bytes seen, 2: output byte waiting, 3: put taken
  task automatic wait_for(input int w, input int n);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge sys_clk);
      if (w == 0 && pops.size() > 0 && pops[$] === 8'h0d) break;
      if (w == 1 && i_host.rxq.size() >= n) break;
      if (w == 2 && host_out_full === 1'b1) break;
      if (w == 3 && (n != 0 ? done_ready : out_ready) === 1'b1) break;
    end
    if (i == 3000)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t timeout", $time);
      tally_and_finish();
    end
  endtask
  // exact byte sequence, then quiet line
  task automatic exp_tx(input logic [7:0] x[$]);
    wait_for(1, x.size());
    repeat (150) @(posedge sys_clk);
    chk(16'(i_host.rxq.size()), 16'(x.size()));
    foreach (x[i]) chk({8'h00, i_host.rxq[i]}, {8'h00, x[i]});
    i_host.rxq.delete();
  endtask
  // ----------------------------------------
  // port drivers
  // ----------------------------------------
  task automatic ser(input string s, input bit pb, input bit fl);
    pops.delete();
    rej = 1'b0;
    for (int i = 0; i < s.len(); i++) i_host.send(s[i], pb, fl);
  endtask
  // dn 0: response char, dn 1: end of command, c[0] = syntax error
  task automatic put(input bit dn, input logic [7:0] c);
    @(posedge sys_clk);
    out_valid <= !dn;
    done_valid <= dn;
    out_data <= c;
    done_syntax_err <= c[0];
    wait_for(3, int'(dn));
    out_valid <= 1'b0;
    done_valid <= 1'b0;
  endtask
  task automatic outs(input string s);
    for (int i = 0; i < s.len(); i++) put(0, s[i]);
  endtask
  task automatic hwr(input logic [7:0] c);
    @(posedge sys_clk);
    host_wr <= 1'b1;
    host_addr <= 3'h7;
    host_wdata <= c;
    @(posedge sys_clk);
    chk({15'h0, host_busy}, 16'h0000);
    host_wr <= 1'b0;
  endtask
  task automatic hrd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    @(posedge sys_clk);
    d = host_rdata;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int h = 0; h < 4; h++)
    begin
      hsm <= 2'(h);
      ser("J\001+\015", 1, 0);
      wait_for(0, 0);
      put(1, 8'h00);
      e = {};
      if (h != 0)
        e.push_back(h == 1 ? 8'h0a : 8'h06);
      e.push_back(8'h75);
      exp_tx(e);
    end
    ser("P100\015", 1, 0);
    wait_for(0, 0);
    outs("\n35\015");
    put(1, 8'h00);
    exp_tx('{8'h0a, 8'h33, 8'h35, 8'h0d, 8'h7f, 8'h06, 8'he1});
    outs("0\015");
    exp_tx('{8'h30, 8'h0d, 8'h3d});
    ccm <= 2'h0;
    hsm <= 2'h2;
    ser("A", 1, 1);
    exp_tx('{8'h07});
    ser("\015", 1, 0);
    wait_for(0, 0);
    exp_tx('{8'h07});
    chk({15'h0, rej}, 16'h0001);
    jmp <= 1'b1;
    ser("C", 1, 0);
    exp_tx('{8'h07});
    ser("\015", 0, 0);
    wait_for(0, 0);
    exp_tx('{8'h07});
    chk(16'(pops.size()), 16'h0001);
    hsm <= 2'h1;
    ser("J\015", 0, 0);
    wait_for(0, 0);
    put(1, 8'h00);
    exp_tx('{8'h0a});
    // check mode 2: bad char stays silent, bell only at line end
    ccm <= 2'h2;
    ser("C", 1, 0);
    ser("\015", 0, 0);
    wait_for(0, 0);
    exp_tx('{8'h07});
    chk({15'h0, rej}, 16'h0001);
    ccm <= 2'h1;
    hsm <= 2'h3;
    ser("\024K", 0, 0);
    exp_tx('{8'h4b});
    ser("\024\015", 0, 0);
    wait_for(0, 0);
    put(1, 8'h01);
    exp_tx('{8'h07});
    use_parallel_port <= 1'b1;
    pops.delete();
    for (int i = 0; i < qs.len(); i++) hwr(qs[i]);
    wait_for(0, 0);
    put(1, 8'h00);
    e.delete();
    for (int k = 0; k < 2; k++)
    begin
      wait_for(2, 0);
      hrd(3'h6, d6);
      hrd(3'h7, d7);
      chk({d6, d7}, k == 0 ? 16'h0006 : 16'h0171);
    end
    hrd(3'h3, d6);
    chk({8'h00, d6}, 16'h0000);
    chk(16'(i_host.bad_cnt), 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
